// [logic/gpa_pin_sync.sv]
// three stage pin input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module gpa_pin_sync #(
    parameter int WIDTH = 29
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinRaw,
    output logic [WIDTH-1:0] pinStable
);
    generate
        if (WIDTH < 1) begin : badWidth
            $error("gpa_pin_sync width must be at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : perPin
            logic stage1_q;
            logic stage2_q;
            logic stage3_q;
            logic stable_q;
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage1_q <= gpa_pkg::SENSE_RESET;
                    stage2_q <= gpa_pkg::SENSE_RESET;
                    stage3_q <= gpa_pkg::SENSE_RESET;
                    stable_q <= gpa_pkg::SENSE_RESET;
                end else begin
                    stage1_q <= pinRaw[i];
                    stage2_q <= stage1_q;
                    stage3_q <= stage2_q;
                    if (stage2_q == stage3_q) begin
                        stable_q <= stage3_q;
                    end
                end
            end
            assign pinStable[i] = stable_q;
        end
    endgenerate
endmodule
`default_nettype wire

// [logic/gpa_port_access.sv]
// gpio port access logic: output, direction and mask state with all register views
//
// Functional notes
// - sense every non-analog pin, any function
// - byte pin read: level in bit zero
// - word pin read replicates level over lanes
// - port read returns all pin levels
// - masked port read zeroes masked pins
// - drive pin only if routed and output
// - byte pin write loads data bit zero
// - word pin write loads OR of data
// - port write loads pins in written lanes
// - masked port write skips masked bits
// - set view ones set output bits
// - clear view ones clear output bits
// - toggle view ones invert output bits
// - set view read returns output bits
// - level views ignore direction and function
// - zero mask makes masked equal port
// - direction bits with set, clear, toggle
// - bit n is pin n, upper reserved zero except word pin read, which replicates level into them
`timescale 1ns/1ns
`default_nettype none
module gpa_port_access #(
    parameter int PIN_COUNT = gpa_pkg::PIN_COUNT_DEF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic accWrite,
    input wire logic accRead,
    input wire logic [gpa_pkg::VIEW_WIDTH-1:0] accView,
    input wire logic [gpa_pkg::PIN_INDEX_WIDTH-1:0] accPin,
    input wire logic [gpa_pkg::LANE_COUNT-1:0] accByteEn,
    input wire logic [gpa_pkg::DATA_WIDTH-1:0] accWrData,
    output logic [gpa_pkg::DATA_WIDTH-1:0] accRdData,
    output logic accRdValid,
    input wire logic [PIN_COUNT-1:0] pinIn,
    input wire logic [PIN_COUNT-1:0] pinAnalog,
    input wire logic [PIN_COUNT-1:0] pinGpioRouted,
    output logic [PIN_COUNT-1:0] pinOut,
    output logic [PIN_COUNT-1:0] pinOe
);
    generate
        if (PIN_COUNT < 1 || PIN_COUNT > 31) begin : badPinCount
            $error("gpa_port_access pin count must be 1 to 31");
        end
    endgenerate

    localparam int PAD = gpa_pkg::DATA_WIDTH - PIN_COUNT;

    logic [PIN_COUNT-1:0] outQ_q;
    logic [PIN_COUNT-1:0] outQ_d;
    logic [PIN_COUNT-1:0] dir_q;
    logic [PIN_COUNT-1:0] dir_d;
    logic [PIN_COUNT-1:0] mask_q;
    logic [PIN_COUNT-1:0] mask_d;
    logic [PIN_COUNT-1:0] oe_q;
    logic [gpa_pkg::DATA_WIDTH-1:0] rdData_q;
    logic [gpa_pkg::DATA_WIDTH-1:0] rdData_d;
    logic rdValid_q;

    // pin sensing
    logic [PIN_COUNT-1:0] pinStable;
    wire [PIN_COUNT-1:0] sensed;

    gpa_pin_sync #(
        .WIDTH(PIN_COUNT)
    ) pinSync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pinRaw(pinIn),
        .pinStable(pinStable)
    );

    assign sensed = pinStable & ~pinAnalog;

    // access decode
    wire [gpa_pkg::DATA_WIDTH-1:0] laneMask32 = {{8{accByteEn[3]}}, {8{accByteEn[2]}},
                                                {8{accByteEn[1]}}, {8{accByteEn[0]}}};
    wire [PIN_COUNT-1:0] laneMask = laneMask32[PIN_COUNT-1:0];
    wire pinValid = ({27'h0, accPin} < PIN_COUNT);
    wire [PIN_COUNT-1:0] pinOne = {{(PIN_COUNT-1){1'b0}}, 1'b1};
    wire [PIN_COUNT-1:0] pinSel = pinValid ? (pinOne << accPin) : '0;
    wire selLevel = |(sensed & pinSel);
    wire wordOr = |(accWrData & laneMask32);
    wire [PIN_COUNT-1:0] wrBits = accWrData[PIN_COUNT-1:0];
    wire [PIN_COUNT-1:0] mportEn = laneMask & ~mask_q;

    // next output and direction state
    always_comb begin
        outQ_d = outQ_q;
        dir_d = dir_q;
        mask_d = mask_q;
        if (accWrite) begin
            case (accView)
                gpa_pkg::VIEW_BYTE_PIN: begin
                    outQ_d = (outQ_q & ~pinSel) | (pinSel & {PIN_COUNT{accWrData[0]}});
                end
                gpa_pkg::VIEW_WORD_PIN: begin
                    outQ_d = (outQ_q & ~pinSel) | (pinSel & {PIN_COUNT{wordOr}});
                end
                gpa_pkg::VIEW_DIRECTION: begin
                    dir_d = (dir_q & ~laneMask) | (wrBits & laneMask);
                end
                gpa_pkg::VIEW_MASK: begin
                    mask_d = (mask_q & ~laneMask) | (wrBits & laneMask);
                end
                gpa_pkg::VIEW_PORT: begin
                    outQ_d = (outQ_q & ~laneMask) | (wrBits & laneMask);
                end
                gpa_pkg::VIEW_MASKED_PORT: begin
                    outQ_d = (outQ_q & ~mportEn) | (wrBits & mportEn);
                end
                gpa_pkg::VIEW_OUTPUT_SET: begin
                    outQ_d = outQ_q | (wrBits & laneMask);
                end
                gpa_pkg::VIEW_OUTPUT_CLEAR: begin
                    outQ_d = outQ_q & ~(wrBits & laneMask);
                end
                gpa_pkg::VIEW_OUTPUT_TOGGLE: begin
                    outQ_d = outQ_q ^ (wrBits & laneMask);
                end
                gpa_pkg::VIEW_DIRECTION_SET: begin
                    dir_d = dir_q | (wrBits & laneMask);
                end
                gpa_pkg::VIEW_DIRECTION_CLEAR: begin
                    dir_d = dir_q & ~(wrBits & laneMask);
                end
                gpa_pkg::VIEW_DIRECTION_TOGGLE: begin
                    dir_d = dir_q ^ (wrBits & laneMask);
                end
                default: begin
                    outQ_d = outQ_q;
                end
            endcase
        end
    end

    // read data selection
    always_comb begin
        rdData_d = gpa_pkg::READ_RESET;
        case (accView)
            gpa_pkg::VIEW_BYTE_PIN: begin
                rdData_d = {31'h0, selLevel};
            end
            gpa_pkg::VIEW_WORD_PIN: begin
                rdData_d = {gpa_pkg::DATA_WIDTH{selLevel}} & laneMask32;
            end
            gpa_pkg::VIEW_DIRECTION: begin
                rdData_d = {{PAD{1'b0}}, dir_q & laneMask};
            end
            gpa_pkg::VIEW_MASK: begin
                rdData_d = {{PAD{1'b0}}, mask_q & laneMask};
            end
            gpa_pkg::VIEW_PORT: begin
                rdData_d = {{PAD{1'b0}}, sensed & laneMask};
            end
            gpa_pkg::VIEW_MASKED_PORT: begin
                rdData_d = {{PAD{1'b0}}, sensed & mportEn};
            end
            gpa_pkg::VIEW_OUTPUT_SET: begin
                rdData_d = {{PAD{1'b0}}, outQ_q & laneMask};
            end
            default: begin
                rdData_d = gpa_pkg::READ_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            outQ_q <= gpa_pkg::OUTPUT_RESET[PIN_COUNT-1:0];
            dir_q <= gpa_pkg::DIRECTION_RESET[PIN_COUNT-1:0];
            mask_q <= gpa_pkg::MASK_RESET[PIN_COUNT-1:0];
        end else begin
            outQ_q <= outQ_d;
            dir_q <= dir_d;
            mask_q <= mask_d;
        end
    end

    // pin drive enable
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_q <= '0;
        end else begin
            oe_q <= dir_d & pinGpioRouted;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= gpa_pkg::READ_RESET;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= accRead;
            if (accRead) begin
                rdData_q <= rdData_d;
            end
        end
    end

    assign pinOut = outQ_q;
    assign pinOe = oe_q;
    assign accRdData = rdData_q;
    assign accRdValid = rdValid_q;
endmodule
`default_nettype wire

// [pkg/gpa_pkg.sv]
// constants shared by the gpio port access logic
package gpa_pkg;
    localparam int DATA_WIDTH = 32;
    localparam int PIN_COUNT_DEF = 29;
    localparam int VIEW_WIDTH = 4;
    localparam int PIN_INDEX_WIDTH = 5;
    localparam int LANE_COUNT = 4;
    localparam int LANE_WIDTH = 8;
    localparam int SYNC_STAGES = 3;

    // access view codes
    localparam logic [3:0] VIEW_BYTE_PIN = 4'h0;
    localparam logic [3:0] VIEW_WORD_PIN = 4'h1;
    localparam logic [3:0] VIEW_DIRECTION = 4'h2;
    localparam logic [3:0] VIEW_MASK = 4'h3;
    localparam logic [3:0] VIEW_PORT = 4'h4;
    localparam logic [3:0] VIEW_MASKED_PORT = 4'h5;
    localparam logic [3:0] VIEW_OUTPUT_SET = 4'h6;
    localparam logic [3:0] VIEW_OUTPUT_CLEAR = 4'h7;
    localparam logic [3:0] VIEW_OUTPUT_TOGGLE = 4'h8;
    localparam logic [3:0] VIEW_DIRECTION_SET = 4'h9;
    localparam logic [3:0] VIEW_DIRECTION_CLEAR = 4'ha;
    localparam logic [3:0] VIEW_DIRECTION_TOGGLE = 4'hb;

    // values after reset
    localparam logic [31:0] OUTPUT_RESET = 32'h00000000;
    localparam logic [31:0] DIRECTION_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] READ_RESET = 32'h00000000;
    localparam logic SENSE_RESET = 1'b0;
endpackage

// [tb/gpa_pin_model.sv]
// board side of the pins: driven bit or board level
`timescale 1ns/1ns
`default_nettype none
module gpa_pin_model #(
    parameter int PIN_COUNT = 29
) (
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe,
    input wire logic [PIN_COUNT-1:0] boardLevel,
    output logic [PIN_COUNT-1:0] pinLevel
);
    // undriven pins fall back to the board pull level
    assign pinLevel = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule
`default_nettype wire

// [tb/gpa_port_access_assertions.sv]
// port checker for the gpio port access block
`timescale 1ns/1ns
`default_nettype none
module gpa_port_access_chk #(
    parameter int PIN_COUNT = 29
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic accWrite,
    input wire logic accRead,
    input wire logic [3:0] accView,
    input wire logic [3:0] accByteEn,
    input wire logic [31:0] accWrData,
    input wire logic [31:0] accRdData,
    input wire logic accRdValid,
    input wire logic [PIN_COUNT-1:0] pinGpioRouted,
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic wrFull = accWrite && accByteEn == 4'hf;
    wire logic [PIN_COUNT-1:0] wrBits = accWrData[PIN_COUNT-1:0];
    a_valid_after_read: assert property (accRead |=> accRdValid)
        else $error("read valid missing");
    a_valid_only_read: assert property (!accRead |=> !accRdValid)
        else $error("stray read valid");
    a_reserved_zero: assert property (accRdValid |-> accRdData[31:PIN_COUNT] == '0)
        else $error("reserved bits set");
    a_byte_upper_zero: assert property (accRead && accView == gpa_pkg::VIEW_BYTE_PIN
        |=> accRdData[31:1] == '0) else $error("byte pin upper bits set");
    a_set_reads_out: assert property (accRead && accView == gpa_pkg::VIEW_OUTPUT_SET
        |=> accRdData[PIN_COUNT-1:0] == $past(pinOut)) else $error("set view read wrong");
    a_set_bits: assert property (wrFull && accView == gpa_pkg::VIEW_OUTPUT_SET
        |=> (pinOut & $past(wrBits)) == $past(wrBits)) else $error("set view failed");
    a_clear_bits: assert property (wrFull && accView == gpa_pkg::VIEW_OUTPUT_CLEAR
        |=> (pinOut & $past(wrBits)) == '0) else $error("clear view failed");
    a_toggle_bits: assert property (wrFull && accView == gpa_pkg::VIEW_OUTPUT_TOGGLE
        |=> (pinOut ^ $past(pinOut)) == $past(wrBits)) else $error("toggle view failed");
    a_oe_needs_route: assert property ((pinOe & ~$past(pinGpioRouted)) == '0)
        else $error("unrouted pin driven");
endmodule
bind gpa_port_access gpa_port_access_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .accWrite(accWrite), .accRead(accRead),
    .accView(accView), .accByteEn(accByteEn), .accWrData(accWrData), .accRdData(accRdData),
    .accRdValid(accRdValid), .pinGpioRouted(pinGpioRouted), .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the gpio port access block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic accWrite = 1'b0;
    logic accRead = 1'b0;
    logic [3:0] accView = 4'h0;
    logic [4:0] accPin = 5'h00;
    logic [3:0] accByteEn = 4'hf;
    logic [31:0] accWrData = 32'h00000000;
    logic [31:0] accRdData, eo, ed, lv;
    logic accRdValid;
    logic [28:0] pinIn, pinOut, pinOe;
    logic [28:0] pinAnalog = 29'h10000000;
    logic [28:0] pinGpioRouted = 29'h1fffffef;
    logic [28:0] boardLvl = 29'h15555555;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    gpa_port_access dut (.core_clk(core_clk), .reset_n(reset_n), .accWrite(accWrite),
        .accRead(accRead), .accView(accView), .accPin(accPin), .accByteEn(accByteEn),
        .accWrData(accWrData), .accRdData(accRdData), .accRdValid(accRdValid), .pinIn(pinIn),
        .pinAnalog(pinAnalog), .pinGpioRouted(pinGpioRouted), .pinOut(pinOut), .pinOe(pinOe));
    gpa_pin_model board (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLvl), .pinLevel(pinIn));
    initial forever #10 core_clk = ~core_clk;
    task automatic complete_run();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic w, input logic [3:0] v, input logic [4:0] p, input logic [31:0] d);
        @(negedge core_clk);
        accWrite = w;
        accRead = !w;
        accView = v;
        accPin = p;
        accWrData = d;
        @(negedge core_clk);
        accWrite = 1'b0;
        accRead = 1'b0;
    endtask
    task automatic rd(input logic [3:0] v, input logic [4:0] p, input logic [31:0] exp);
        req(1'b0, v, p, 32'h00000000);
        // valid stands only in the cycle after the taking edge
        chk({31'h0, accRdValid}, 32'h00000001);
        chk(accRdData, exp);
    endtask
    task automatic setOut(input logic [31:0] exp);
        rd(gpa_pkg::VIEW_OUTPUT_SET, 5'h00, exp);
        eo = exp;
    endtask
    // expected sensed levels from the bench's own state
    function automatic logic [31:0] lvl();
        return {3'h0, ((ed[28:0] & pinGpioRouted & eo[28:0])
            | (~(ed[28:0] & pinGpioRouted) & boardLvl)) & ~pinAnalog};
    endfunction
    initial begin
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        ed = 32'h00000000;
        setOut(32'h00000000);
        chk({3'h0, pinOe}, 32'h00000000);
        req(1'b1, gpa_pkg::VIEW_PORT, 5'h00, 32'hf2345678);
        setOut(32'h12345678);
        accByteEn = 4'h1;
        req(1'b1, gpa_pkg::VIEW_PORT, 5'h00, 32'h00000000);
        accByteEn = 4'hf;
        setOut(32'h12345600);
        req(1'b1, gpa_pkg::VIEW_OUTPUT_SET, 5'h00, 32'h000000ff);
        req(1'b1, gpa_pkg::VIEW_OUTPUT_CLEAR, 5'h00, 32'h12000000);
        setOut(32'h003456ff);
        req(1'b1, gpa_pkg::VIEW_OUTPUT_TOGGLE, 5'h00, 32'h1fffffff);
        setOut(32'h1fcba900);
        $display("test output views done");
        req(1'b1, gpa_pkg::VIEW_BYTE_PIN, 5'h08, 32'h000000fe);
        req(1'b1, gpa_pkg::VIEW_WORD_PIN, 5'h00, 32'h01000000);
        req(1'b1, gpa_pkg::VIEW_WORD_PIN, 5'h0b, 32'h00000000);
        setOut(32'h1fcba001);
        req(1'b1, gpa_pkg::VIEW_DIRECTION_SET, 5'h00, 32'h0000ffff);
        req(1'b1, gpa_pkg::VIEW_DIRECTION_CLEAR, 5'h00, 32'h0000ff00);
        req(1'b1, gpa_pkg::VIEW_DIRECTION_TOGGLE, 5'h00, 32'h00000f0f);
        ed = 32'h00000ff0;
        rd(gpa_pkg::VIEW_DIRECTION, 5'h00, ed);
        chk({3'h0, pinOe}, 32'h00000fe0);
        $display("test pin writes and direction done");
        repeat (8) @(negedge core_clk);
        lv = lvl();
        rd(gpa_pkg::VIEW_PORT, 5'h00, lv);
        rd(gpa_pkg::VIEW_BYTE_PIN, 5'h04, {31'h0, lv[4]});
        rd(gpa_pkg::VIEW_BYTE_PIN, 5'h1c, 32'h00000000);
        accByteEn = 4'h3;
        rd(gpa_pkg::VIEW_WORD_PIN, 5'h02, 32'h0000ffff);
        accByteEn = 4'hf;
        req(1'b1, gpa_pkg::VIEW_MASK, 5'h00, 32'h0000ff00);
        rd(gpa_pkg::VIEW_MASKED_PORT, 5'h00, lv & 32'hffff00ff);
        req(1'b1, gpa_pkg::VIEW_MASKED_PORT, 5'h00, 32'h00000000);
        setOut(eo & 32'h0000ff00);
        req(1'b1, gpa_pkg::VIEW_MASK, 5'h00, 32'h00000000);
        repeat (8) @(negedge core_clk);
        rd(gpa_pkg::VIEW_MASKED_PORT, 5'h00, lvl());
        req(1'b1, gpa_pkg::VIEW_MASKED_PORT, 5'h00, 32'h00000fff);
        setOut(32'h00000fff);
        rd(4'hc, 5'h00, 32'h00000000);
        $display("test sensing and mask done");
        complete_run();
    end
endmodule
`default_nettype wire
